//--- testbench/brmc_chk.sv
// Purpose: port-level assertions for brmc_top
// Assumes: one clock domain, synchronous active-high reset
// Notes:   pin and supply resets are held several cycles to cover synchroniser delay
module brmc_chk
    import brmc_pkg::*;
#(
    parameter int POWER_UP_TIMER_CYC = 20  // matches the design's power_up_timer length
) (
    input wire logic    mclk_i,
    input wire logic    sys_rst_i,
    input wire logic    supply_good_i,
    input wire logic    external_reset_pin_n_i,
    input wire brmc_rst_src_t rst_src_i,
    input wire logic    sleep_i,
    input wire logic    bulk_erase_i,
    input wire brmc_det_t det_ctrl_o,
    input wire logic    device_reset_o,
    input wire logic    cpu_run_o,
    input wire logic    erase_abort_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // pin held long enough to pass the input synchronisers, erase and source only past the output flops
    sequence s_erase_held; bulk_erase_i ##1 bulk_erase_i; endsequence
    sequence s_pin_low; !external_reset_pin_n_i [*7]; endsequence
    sequence s_src_held; (|rst_src_i) [*3]; endsequence
    a_release_held: assert property ($fell(sys_rst_i) |-> device_reset_o && !cpu_run_o)
        else $error("outputs not held after release");
    a_run_excl: assert property (cpu_run_o |-> !device_reset_o)
        else $error("run during reset");
    a_sleep_halts: assert property (sleep_i |=> !cpu_run_o)
        else $error("running in sleep");
    a_erase_force: assert property (s_erase_held |-> det_ctrl_o.enable &&
        det_ctrl_o.level == BRMC_LVL_ERASE) else $error("detector not forced");
    a_abort_quiet: assert property (erase_abort_o |=> !device_reset_o)
        else $error("abort caused reset");
    a_pin_reset: assert property (s_pin_low |-> device_reset_o)
        else $error("pin reset missed");
    a_src_reset: assert property (s_src_held |-> device_reset_o)
        else $error("source reset missed");
    a_supply_por: assert property (!supply_good_i [*7] |-> device_reset_o)
        else $error("power-on reset missed");
endmodule : brmc_chk

bind brmc_top brmc_chk #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER_CYC)) u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .supply_good_i(supply_good_i), .external_reset_pin_n_i(external_reset_pin_n_i),
    .rst_src_i(rst_src_i), .sleep_i(sleep_i), .bulk_erase_i(bulk_erase_i),
    .det_ctrl_o(det_ctrl_o), .device_reset_o(device_reset_o), .cpu_run_o(cpu_run_o),
    .erase_abort_o(erase_abort_o));

//--- testbench/brownout_reset_mode_control_test.sv
// Purpose: self-checking bench for brmc_top
// Assumes: mode field resets to 11, power_up_timer shortened to 20 cycles
// Notes:   bus answers are checked against an expectation queue
module brownout_reset_mode_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import brmc_pkg::*;
    // bready and rready stay high, so back-to-back calls never drive them twice in one step
    logic mclk_i = 1'h0, sys_rst_i = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h1, arv = 1'h0;
    logic rry = 1'h1, dr = 1'h1, tp = 1'h0, sg = 1'h1, lp = 1'h0, pn = 1'h1, sl = 1'h0, be = 1'h0;
    logic [7:0] aa = '0, ra = '0;
    logic [31:0] wd = '0, rd;
    logic awr, wr, bv, arr, rv, dres, run, ab;
    logic [1:0] br, rr;
    brmc_rst_src_t rs = '0;
    brmc_det_t dc;
    logic [33:0] exp_q[$];  // oldest expected bus answer first
    int fail_count = 0, tests_run = 0;
    always #4 mclk_i = ~mclk_i;
    brmc_top #(.POWER_UP_TIMER_CYC(20)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(aa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .det_ready_i(dr), .det_trip_i(tp), .supply_good_i(sg), .low_power_brownout_i(lp),
        .external_reset_pin_n_i(pn), .rst_src_i(rs), .sleep_i(sl), .bulk_erase_i(be),
        .det_ctrl_o(dc), .device_reset_o(dres), .cpu_run_o(run), .erase_abort_o(ab));
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic ck(input logic [3:0] g, input logic [3:0] e);
        chk({30'h0, g}, {30'h0, e});
    endtask : ck
    task automatic cy(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cy
    task automatic final_report;
        $display("mismatches %0d, checks %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        exp_q.push_back({r, 32'h0});
        aa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        do begin
            @(posedge mclk_i);
            if (awr) awv <= 1'h0;
            if (wr) wv <= 1'h0;
        end while ((awv && !awr) || (wv && !wr));
        do @(posedge mclk_i); while (!bv);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        ra <= a;
        arv <= 1'h1;
        do @(posedge mclk_i); while (!arr);
        arv <= 1'h0;
        do @(posedge mclk_i); while (!rv);
    endtask : axr
    // answers are taken at the handshake edge, before the DUT drops valid
    always @(posedge mclk_i) begin
        if (bv && bry) chk({br, 32'h0}, exp_q.pop_front());
        if (rv && rry) chk({rr, rd}, exp_q.pop_front());
    end
    initial begin
        #400us;
        fail_count++;
        final_report;
    end
    initial begin
        logic [31:0] d;
        void'($urandom(4));
        cy(12);
        sys_rst_i <= 1'h0;
        cy(80);
        ck({dres, run}, 4'h1);
        axr(BRMC_OFS_CTRL, 34'h81);
        axr(BRMC_OFS_CFG, 34'h13);
        axr(BRMC_OFS_STATUS, 34'h3);
        axr(8'h0C, {BRMC_RESP_SLVERR, 32'h0});
        d = $urandom;
        axw(8'h0C, d, BRMC_RESP_SLVERR);
        axw(BRMC_OFS_CTRL, d);
        axr(BRMC_OFS_CTRL, {26'h0, d[7], 7'h1});
        sl <= 1'h1;
        dr <= 1'h0;
        cy(6);
        ck({run, dc.enable}, 4'h1);
        sl <= 1'h0;
        cy(3);
        ck({run, dc.enable}, 4'h3);
        dr <= 1'h1;
        axw(BRMC_OFS_CFG, 32'h1A);
        sl <= 1'h1;
        dr <= 1'h0;
        cy(4);
        ck({dc.enable, dc.hibernate}, 4'h1);
        ck({2'h0, dc.level}, 4'h2);
        sl <= 1'h0;
        cy(10);
        ck({3'h0, run}, 4'h0);
        dr <= 1'h1;
        cy(8);
        ck({3'h0, run}, 4'h1);
        axw(BRMC_OFS_CFG, 32'h11);
        axw(BRMC_OFS_CTRL, 32'h0);
        cy(6);
        ck({dc.enable, run}, 4'h1);
        axr(BRMC_OFS_CTRL, 34'h0);
        axw(BRMC_OFS_CTRL, 32'h80);
        sl <= 1'h1;
        cy(6);
        ck({dc.enable, dc.hibernate}, 4'h2);
        sl <= 1'h0;
        axr(BRMC_OFS_CTRL, 34'h81);
        axw(BRMC_OFS_CFG, 32'h10);
        cy(4);
        ck({dc.enable, dc.hibernate}, 4'h0);
        be <= 1'h1;
        tp <= 1'h1;
        cy(140);
        ck({dc.enable, dc.level, ab}, 4'hF);
        tp <= 1'h0;
        be <= 1'h0;
        axw(BRMC_OFS_CFG, 32'h13);
        for (int i = 0; i < 11; i++) begin
            tp <= (i < 2);
            sg <= (i != 2);
            rs <= brmc_rst_src_t'((i > 2 && i < 9) ? (6'h1 << (i - 3)) : 6'h0);
            lp <= (i == 9);
            pn <= (i != 10);
            cy(i == 0 ? 100 : 140);
            ck({3'h0, dres}, {3'h0, i != 0});
            {sg, tp, rs, lp, pn} <= 10'h201;
            cy(80);
            ck({3'h0, run}, 4'h1);
        end
        sg <= 1'h0;
        cy(10);
        ck({dres, run}, 4'h2);
        final_report;
    end
endmodule : brownout_reset_mode_control_test

//--- verilog/brmc_pkg.sv
// Purpose: shared constants and carrier types for the brown-out mode control block
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz system clock
// Notes:   every offset, control and configuration field position and reset value, and every timing figure lives here
package brmc_pkg;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] BRMC_OFS_CTRL   = 8'h00;  // brownout_control
    localparam logic [7:0] BRMC_OFS_CFG    = 8'h04;  // configuration word image
    localparam logic [7:0] BRMC_OFS_STATUS = 8'h08;  // sequencer and reset state

    // brownout_control fields
    localparam int         BRMC_CTRL_SWEN_BIT = 7;   // sw_brownout_enable
    localparam int         BRMC_CTRL_RDY_BIT  = 0;   // brownout_ready
    localparam logic       BRMC_SWEN_RST      = 1'b1;

    // configuration register fields
    localparam int         BRMC_CFG_MODE_LSB  = 0;   // brownout_mode_select[1:0]
    localparam int         BRMC_CFG_LVL_LSB   = 2;   // brownout_level_select[1:0]
    localparam int         BRMC_CFG_POWER_UP_TIMER_BIT  = 4;   // power_up_timer enable
    localparam logic [1:0] BRMC_MODE_RST      = 2'h3;
    localparam logic [1:0] BRMC_LVL_RST       = 2'h0;
    localparam logic       BRMC_POWER_UP_TIMER_RST      = 1'b1;

    // mode codes of brownout_mode_select
    localparam logic [1:0] BRMC_MODE_OFF      = 2'h0;
    localparam logic [1:0] BRMC_MODE_SW       = 2'h1;
    localparam logic [1:0] BRMC_MODE_NOSLEEP  = 2'h2;
    localparam logic [1:0] BRMC_MODE_ALWAYS   = 2'h3;

    // level code driven to the detector during a program_flash bulk erase (2.45V)
    localparam logic [1:0] BRMC_LVL_ERASE     = 2'h3;

    // timing: brownout_filter_time and power_up_timer
    localparam int         BRMC_CLK_MHZ       = 125;
    localparam int         BRMC_FILTER_NS     = 1000;
    localparam int         BRMC_FILTER_CYC    = (BRMC_FILTER_NS * BRMC_CLK_MHZ + 999) / 1000;
    localparam int         BRMC_POWER_UP_TIMER_US       = 64;
    localparam int         BRMC_POWER_UP_TIMER_CYC      = BRMC_POWER_UP_TIMER_US * BRMC_CLK_MHZ;

    // AXI response codes
    localparam logic [1:0] BRMC_RESP_OKAY     = 2'h0;
    localparam logic [1:0] BRMC_RESP_SLVERR   = 2'h2;

    // drive to the analog detector
    typedef struct packed {
        logic       enable;     // detector powered and comparing
        logic       hibernate;  // detector parked, no protection
        logic [1:0] level;      // brownout_threshold select
    } brmc_det_t;

    // same-clock reset requests from the rest of the device
    typedef struct packed {
        logic watchdog;
        logic reset_instr;
        logic stack_ovf;
        logic stack_unf;
        logic prog_exit;
        logic exec_violation_reset;
    } brmc_rst_src_t;

    // start-up sequencer states
    typedef enum logic [1:0] {
        BRMC_ST_RESET = 2'b00,
        BRMC_ST_POWER_UP_TIMER  = 2'b01,
        BRMC_ST_WAIT  = 2'b10,
        BRMC_ST_RUN   = 2'b11
    } brmc_state_t;

endpackage : brmc_pkg

//--- verilog/brmc_top.sv
// Purpose: brown-out reset mode control, start-up gating and device reset combining
// Assumes: analog detector, supply monitor and pin are asynchronous to mclk_i
// Notes:   registers reached over AXI4-Lite; no interrupt, one clock, no buffering
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module brmc_top #(
    parameter int POWER_UP_TIMER_CYC = brmc_pkg::BRMC_POWER_UP_TIMER_CYC  // power_up_timer length in cycles
) (
    input  wire logic                   mclk_i,
    input  wire logic                   sys_rst_i,
    // AXI4-Lite slave
    input  wire logic [7:0]             s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [31:0]            s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic [1:0]                  s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [7:0]             s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic [31:0]                 s_axi_rdata_o,
    output logic [1:0]                  s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i,
    // analog side, asynchronous
    input  wire logic                   det_ready_i,
    input  wire logic                   det_trip_i,
    input  wire logic                   supply_good_i,
    input  wire logic                   low_power_brownout_i,
    input  wire logic                   external_reset_pin_n_i,
    // same-clock device side
    input  wire brmc_pkg::brmc_rst_src_t rst_src_i,
    input  wire logic                   sleep_i,
    input  wire logic                   bulk_erase_i,
    // outputs
    output brmc_pkg::brmc_det_t         det_ctrl_o,
    output logic                        device_reset_o,
    output logic                        cpu_run_o,
    output logic                        erase_abort_o
);
    import brmc_pkg::*;

    localparam int NSYNC = 5;                    // number of asynchronous inputs
    localparam int FCW   = 16;                   // filter counter width
    localparam int PCW   = 24;                   // power_up_timer counter width

    // three-stage synchronisers and the agreed value
    logic [NSYNC-1:0] sync1_r;                   // first stage, read only by stage two
    logic [NSYNC-1:0] sync2_r;                   // second stage
    logic [NSYNC-1:0] sync3_r;                   // third stage
    logic [NSYNC-1:0] in_r;                      // value once stages two and three agree

    // named views of the cleaned inputs
    logic             ready_s;                   // detector ready
    logic             trip_s;                    // supply below threshold
    logic             supply_ok_s;               // supply-good from power-on monitor
    logic             low_power_brownout_s;                   // low_power_brownout request
    logic             pin_n_s;                   // external_reset_pin level

    // configuration and control state
    logic             sw_enable_r;               // sw_brownout_enable
    logic [1:0]       mode_r;                    // brownout_mode_select
    logic [1:0]       level_r;                   // brownout_level_select
    logic             power_up_timer_en_r;                 // power_up_timer enable

    // detector control and protection
    logic             det_active;                // detector on in the current state
    logic             armed;                     // active and ready: protection live
    logic [FCW-1:0]   filt_cnt_r;                // length of the present dip
    logic             bor_req;                   // filtered brown-out request
    logic             bor_generic;               // brown-out or low-power brown-out
    logic             por_req;                   // power-on reset request
    logic             any_rst;                   // every reset source ORed

    // start-up sequencer
    brmc_state_t      state_r;                   // sequencer state
    brmc_state_t      state_nxt;                 // next sequencer state
    logic [PCW-1:0]   power_up_timer_cnt_r;                // power_up_timer count
    logic             pwr_evt_r;                 // power-on or brown-out seen since run
    logic             wake_hold_r;               // mode 10 wake-up waiting for ready
    logic             gate_ok;                   // readiness condition for start-up

    // AXI bookkeeping
    logic             aw_got_r;                  // write address captured
    logic             w_got_r;                   // write data captured
    logic [7:0]       aw_addr_r;                 // captured write address
    logic [31:0]      w_data_r;                  // captured write data
    logic [3:0]       w_strb_r;                  // captured byte strobes

    // a bit follows stage two only where stage three agrees with it
    function automatic logic [NSYNC-1:0] agree(input logic [NSYNC-1:0] s2,
                                               input logic [NSYNC-1:0] s3,
                                               input logic [NSYNC-1:0] old);
        logic [NSYNC-1:0] diff;
        diff  = s2 ^ s3;
        agree = (~diff & s2) | (diff & old);
    endfunction : agree

    // register read mux, shared by the read channel
    function automatic logic [31:0] reg_read(input logic [7:0] addr);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            BRMC_OFS_CTRL: begin
                v[BRMC_CTRL_SWEN_BIT] = sw_enable_r;
                v[BRMC_CTRL_RDY_BIT]  = armed;
            end
            BRMC_OFS_CFG: begin
                v[BRMC_CFG_MODE_LSB +: 2] = mode_r;
                v[BRMC_CFG_LVL_LSB +: 2]  = level_r;
                v[BRMC_CFG_POWER_UP_TIMER_BIT]      = power_up_timer_en_r;
            end
            BRMC_OFS_STATUS: begin
                v[1:0] = state_r;
                v[2]   = wake_hold_r;
                v[3]   = bor_generic;
                v[4]   = por_req;
            end
            default: v = 32'h0000_0000;
        endcase
        reg_read = v;
    endfunction : reg_read

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == BRMC_OFS_CTRL) || (addr == BRMC_OFS_CFG) ||
                 (addr == BRMC_OFS_STATUS);
    endfunction : mapped

    // synchronise the analog and pin inputs; reset value assumes a dead supply
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sync1_r <= 5'h10;
            sync2_r <= 5'h10;
            sync3_r <= 5'h10;
            in_r    <= 5'h10;
        end else begin
            sync1_r <= {external_reset_pin_n_i, low_power_brownout_i, supply_good_i,
                        det_trip_i, det_ready_i};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            in_r    <= agree(sync2_r, sync3_r, in_r);
        end
    end

    assign ready_s     = in_r[0];
    assign trip_s      = in_r[1];
    assign supply_ok_s = in_r[2];
    assign low_power_brownout_s     = in_r[3];
    assign pin_n_s     = in_r[4];

    // detector on/off per mode; bulk erase overrides every mode
    always_comb begin
        case (mode_r)
            BRMC_MODE_ALWAYS:  det_active = 1'b1;
            BRMC_MODE_NOSLEEP: det_active = !sleep_i;
            BRMC_MODE_SW:      det_active = sw_enable_r;
            default:           det_active = 1'b0;
        endcase
        if (bulk_erase_i) begin
            det_active = 1'b1;
        end
    end

    // protection is live only with the detector on and reporting ready
    assign armed = det_active && ready_s;

    // drive the detector from flops; level forced to the erase threshold during bulk erase
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            det_ctrl_o <= '{enable: 1'b0, hibernate: 1'b0, level: BRMC_LVL_RST};
        end else begin
            det_ctrl_o.enable    <= det_active;
            // off modes are disabled, the rest hibernate when not active
            det_ctrl_o.hibernate <= !det_active && (mode_r != BRMC_MODE_OFF);
            det_ctrl_o.level     <= bulk_erase_i ? BRMC_LVL_ERASE : level_r;
        end
    end

    // dip filter: the count only grows while a trip persists on an armed detector
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            filt_cnt_r <= '0;
        end else if (!(armed && trip_s)) begin
            filt_cnt_r <= '0;
        end else if (filt_cnt_r != FCW'(BRMC_FILTER_CYC)) begin
            filt_cnt_r <= filt_cnt_r + 1'b1;
        end
    end

    // erase trip aborts instead of resetting; abort flag covers the cycle after erase ends
    assign bor_req     = (filt_cnt_r == FCW'(BRMC_FILTER_CYC)) && !bulk_erase_i &&
                         !erase_abort_o;
    assign bor_generic = bor_req || low_power_brownout_s;
    assign por_req     = !supply_ok_s;
    assign any_rst     = por_req || bor_generic || !pin_n_s ||
                         rst_src_i.watchdog || rst_src_i.reset_instr ||
                         rst_src_i.stack_ovf || rst_src_i.stack_unf ||
                         rst_src_i.prog_exit ||
                         rst_src_i.exec_violation_reset;

    // erase abort flag follows a filtered trip while erasing
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            erase_abort_o <= 1'b0;
        end else begin
            erase_abort_o <= bulk_erase_i &&
                             (filt_cnt_r == FCW'(BRMC_FILTER_CYC));
        end
    end

    // start-up readiness: after a power-on or brown-out, modes 11 and 10 wait for ready and supply above threshold
    assign gate_ok = !pwr_evt_r ||
                     !((mode_r == BRMC_MODE_ALWAYS) || (mode_r == BRMC_MODE_NOSLEEP)) ||
                     (ready_s && !trip_s);

    // start-up sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BRMC_ST_RESET: begin
                if (!any_rst) begin
                    // timer only after a power-on or brown-out, and only with power_up_timer enabled
                    state_nxt = (pwr_evt_r && power_up_timer_en_r) ? BRMC_ST_POWER_UP_TIMER
                                                         : BRMC_ST_WAIT;
                end
            end
            BRMC_ST_POWER_UP_TIMER: begin
                if (power_up_timer_cnt_r == PCW'(POWER_UP_TIMER_CYC - 1)) begin
                    state_nxt = BRMC_ST_WAIT;
                end
            end
            BRMC_ST_WAIT: begin
                if (gate_ok) begin
                    state_nxt = BRMC_ST_RUN;
                end
            end
            BRMC_ST_RUN: state_nxt = BRMC_ST_RUN;
            default:     state_nxt = BRMC_ST_RESET;
        endcase
        if (any_rst) begin
            state_nxt = BRMC_ST_RESET;
        end
    end

    // sequencer state, timer and device reset output
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_r        <= BRMC_ST_RESET;
            power_up_timer_cnt_r     <= '0;
            device_reset_o <= 1'b1;
        end else begin
            state_r        <= state_nxt;
            power_up_timer_cnt_r     <= (state_r == BRMC_ST_POWER_UP_TIMER) ? power_up_timer_cnt_r + 1'b1 : '0;
            device_reset_o <= (state_nxt != BRMC_ST_RUN);
        end
    end

    // remember a power-on or brown-out until the device runs again
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pwr_evt_r <= 1'b1;
        end else if (por_req || bor_generic) begin
            pwr_evt_r <= 1'b1;                                         // set wins over clear
        end else if (state_r == BRMC_ST_RUN) begin
            pwr_evt_r <= 1'b0;
        end
    end

    // mode 10 wake-up waits for ready; mode 11 and 01 resume at once
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wake_hold_r <= 1'b0;
        end else if (sleep_i && (mode_r == BRMC_MODE_NOSLEEP) && !bulk_erase_i) begin
            wake_hold_r <= 1'b1;
        end else if (ready_s || (mode_r != BRMC_MODE_NOSLEEP)) begin
            wake_hold_r <= 1'b0;
        end
    end

    // cpu may execute when out of reset, awake and not held for wake-up
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cpu_run_o <= 1'b0;
        end else begin
            cpu_run_o <= (state_nxt == BRMC_ST_RUN) && !sleep_i && !wake_hold_r;
        end
    end

    // write address and data channels, taken in either order
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            aw_got_r        <= 1'b0;
            w_got_r         <= 1'b0;
            aw_addr_r       <= 8'h00;
            w_data_r        <= 32'h0000_0000;
            w_strb_r        <= 4'h0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= BRMC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_got_r        <= 1'b1;
                aw_addr_r       <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_got_r        <= 1'b1;
                w_data_r       <= s_axi_wdata_i;
                w_strb_r       <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid_o) begin
                // response one cycle after both halves are held
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= mapped(aw_addr_r) ? BRMC_RESP_OKAY : BRMC_RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o  <= 1'b0;
                aw_got_r        <= 1'b0;
                w_got_r         <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // software enable: back to 1 on power-on and brown-out, kept on other resets
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sw_enable_r <= BRMC_SWEN_RST;
        end else if (por_req || bor_generic) begin
            sw_enable_r <= BRMC_SWEN_RST;
        end else if (aw_got_r && w_got_r && !s_axi_bvalid_o &&
                     (aw_addr_r == BRMC_OFS_CTRL) && w_strb_r[0]) begin
            sw_enable_r <= w_data_r[BRMC_CTRL_SWEN_BIT];
        end
    end

    // configuration word image, written once both write halves are held
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_r    <= BRMC_MODE_RST;
            level_r   <= BRMC_LVL_RST;
            power_up_timer_en_r <= BRMC_POWER_UP_TIMER_RST;
        end else if (aw_got_r && w_got_r && !s_axi_bvalid_o &&
                     (aw_addr_r == BRMC_OFS_CFG) && w_strb_r[0]) begin
            mode_r    <= w_data_r[BRMC_CFG_MODE_LSB +: 2];
            level_r   <= w_data_r[BRMC_CFG_LVL_LSB +: 2];
            power_up_timer_en_r <= w_data_r[BRMC_CFG_POWER_UP_TIMER_BIT];
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= BRMC_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= reg_read(s_axi_araddr_i);
            s_axi_rresp_o   <= mapped(s_axi_araddr_i) ? BRMC_RESP_OKAY : BRMC_RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

endmodule : brmc_top
